// ### hw/lgm_pkg.sv
// Package for the auxiliary pin, clock-output and indicator mux block.
// Assumes one 40 MHz clock domain and a plain register port with
// 12-bit address and 16-bit data.
package lgm_pkg;

  // ==========================================================================
  // Clock and register port geometry
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 16;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_PIN_MUX     = 12'h0463;
  localparam logic [ADDR_W-1:0] ADDR_STRAP_LOW   = 12'h0467;
  localparam logic [ADDR_W-1:0] ADDR_STRAP_HIGH  = 12'h0468;
  localparam logic [ADDR_W-1:0] ADDR_IND_POL_OVR = 12'h0469;

  // ==========================================================================
  // Reset values and read masks
  // ==========================================================================
  localparam logic [DATA_W-1:0] RST_PIN_MUX      = 16'h0000;
  localparam logic [DATA_W-1:0] RST_IND_POL_OVR  = 16'h0000;
  localparam logic [DATA_W-1:0] MASK_IND_POL_OVR = 16'h0777;
  localparam logic [DATA_W-1:0] READ_IDLE        = 16'h0000;

  // ==========================================================================
  // Output-select codes shared by the aux pin and the clock pin
  // ==========================================================================
  localparam logic [2:0] SEL_IND1  = 3'h0;
  localparam logic [2:0] SEL_CLOCK = 3'h1;
  localparam logic [2:0] SEL_IRQ   = 3'h2;
  localparam logic [2:0] SEL_LOW   = 3'h3;
  localparam logic [2:0] SEL_ZERO  = 3'h6;
  localparam logic [2:0] SEL_ONE   = 3'h7;

  // Clock-source codes 0..6 and 8..13 carry a clock; the rest are reserved
  localparam int unsigned        NUM_CLK_SRC   = 16;
  localparam logic [NUM_CLK_SRC-1:0] CLK_SRC_VALID = 16'h3F7F;

  // ==========================================================================
  // Field layouts
  // ==========================================================================
  typedef struct packed {
    logic [2:0] aux_src;
    logic [2:0] aux_sel;
    logic       transmit_error_remap;
    logic       clk_div2;
    logic [3:0] clk_src;
    logic       clk_inv;
    logic [2:0] clk_sel;
  } lgm_pin_mux_t;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic       ind2_pol;
    logic       ind2_val;
    logic       ind2_en;
    logic       rsvd_2;
    logic       ind1_pol;
    logic       ind1_val;
    logic       ind1_en;
    logic       rsvd_1;
    logic       ind0_pol;
    logic       ind0_val;
    logic       ind0_en;
  } lgm_ind_cfg_t;

  // Strap vector, bit 0 at the bottom
  typedef struct packed {
    logic [9:0] upper;
    logic       aux_pin;
    logic       ind0;
    logic       ind2;
    logic       rx_err;
    logic       rx_ctrl;
    logic       clk_ind1;
    logic       rx_d0;
    logic       rx_d1;
    logic       rx_d2;
    logic       rx_d3;
  } lgm_strap_t;

  // ==========================================================================
  // Shared decode
  // ==========================================================================
  function automatic logic lgm_pin_level(input logic [2:0] sel, input logic ind1,
                                         input logic clk_lvl, input logic irq);
    logic lvl;
    lvl = 1'b0;
    unique case (sel)
      SEL_IND1:  lvl = ind1;
      SEL_CLOCK: lvl = clk_lvl;
      SEL_IRQ:   lvl = irq;
      SEL_ONE:   lvl = 1'b1;
      default:   lvl = 1'b0;
    endcase
    return lvl;
  endfunction : lgm_pin_level

  function automatic logic lgm_ind_level(input logic evt, input logic pol,
                                         input logic en, input logic val);
    return en ? val : (pol ? evt : ~evt);
  endfunction : lgm_ind_level

endpackage : lgm_pkg

// ### hw/lgm_clk_path.sv
// Clock-source select, divide-by-two and inversion for one output pin.
// Assumes the source levels are synchronous to clk_i.
`timescale 1ns/10ps
module lgm_clk_path
  import lgm_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // Sources and controls
  input  wire logic [NUM_CLK_SRC-1:0] src_i,
  input  wire logic [3:0]             code_i,
  input  wire logic                   div2_i,
  input  wire logic                   inv_i,
  // Conditioned clock level
  output logic                        clk_o
);

  logic sel_q;
  logic valid_q;
  logic div_q;
  logic path;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      sel_q   <= CLK_SRC_VALID[code_i] & src_i[code_i];
      valid_q <= CLK_SRC_VALID[code_i];
    end
  end

  // Divider toggles on each rising edge of the selected source
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_q <= 1'b0;
    end else if (CLK_SRC_VALID[code_i] & src_i[code_i] & ~sel_q) begin
      div_q <= ~div_q;
    end
  end

  // Divide first, then invert; reserved codes hold low
  assign path = div2_i ? div_q : sel_q; // RULE_04 RULE_15

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clk_o <= 1'b0;
    end else begin
      clk_o <= valid_q & (path ^ inv_i); // RULE_06 RULE_15
    end
  end

endmodule : lgm_clk_path

// ### hw/lgm_strap_capture.sv
// Captures the strap vector once, at the first edge after reset release.
// Assumes the strap levels are stable around the release of reset.
`timescale 1ns/10ps
module lgm_strap_capture
  import lgm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Strap pins
  input  wire lgm_strap_t strap_i,
  // Latched vector
  output lgm_strap_t      strap_o
);

  logic done_q;

  // Clocked capture keeps the reset value a constant
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_q  <= 1'b0;
      strap_o <= '0;
    end else if (!done_q) begin
      done_q  <= 1'b1;
      strap_o <= strap_i; // RULE_08
    end
  end

endmodule : lgm_strap_capture

// ### hw/lgm_pin_mux.sv
// Top of the auxiliary pin, clock-output pin and indicator mux block.
// Assumes one 40 MHz clock, clock sources and indicator events sampled
// as levels on it, and a register port answering reads one cycle later.
//
// What this block does
// RULE_01 - Aux pin clock source code selects clock
// RULE_02 - Aux pin select: indicator, clock, irq, levels
// RULE_03 - Remap bit turns indicator 2 into input
// RULE_04 - Divide bit halves clock pin frequency
// RULE_05 - Clock pin source codes 0-6, 8-13
// RULE_06 - Invert bit inverts clock pin clock
// RULE_07 - Clock pin select: indicator, clock, irq, levels
// RULE_08 - Strap levels latched and read only
// RULE_09 - Indicator 2 polarity sets active level
// RULE_10 - Indicator 2 override drives held value
// RULE_11 - Indicator 1 polarity sets active level
// RULE_12 - Indicator 1 override drives held value
// RULE_13 - Indicator 0 polarity sets active level
// RULE_14 - Indicator 0 override drives held value
// RULE_15 - Reserved codes low; divide before invert
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module lgm_pin_mux
  import lgm_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // Register port
  input  wire logic [ADDR_W-1:0]      reg_addr_i,
  input  wire logic [DATA_W-1:0]      reg_wdata_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_re_i,
  output logic      [DATA_W-1:0]      reg_rdata_o,
  // Internal sources
  input  wire logic [NUM_CLK_SRC-1:0] clk_src_i,
  input  wire logic [2:0]             ind_evt_i,
  input  wire logic                   irq_i,
  input  wire lgm_strap_t             strap_i,
  // Indicator 2 pin, two-way
  input  wire logic                   ind2_pin_i,
  output logic                        ind2_pin_o,
  output logic                        ind2_pin_oe_o,
  // Other pins
  output logic                        ind0_pin_o,
  output logic                        aux_pin_o,
  output logic                        clk_pin_o,
  output logic                        tx_er_o
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  lgm_pin_mux_t mux_q;
  lgm_ind_cfg_t ind_q;
  lgm_strap_t   strap_q;
  logic         aux_clk;
  logic         pin_clk;
  logic         ind0_lvl;
  logic         ind1_lvl;
  logic         ind2_lvl;

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mux_q <= RST_PIN_MUX;
    end else if (reg_we_i && reg_addr_i == ADDR_PIN_MUX) begin
      mux_q <= reg_wdata_i;
    end
  end

  // Reserved bits never store, so they read back as zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ind_q <= RST_IND_POL_OVR;
    end else if (reg_we_i && reg_addr_i == ADDR_IND_POL_OVR) begin
      ind_q <= reg_wdata_i & MASK_IND_POL_OVR;
    end
  end

  // ==========================================================================
  // Register reads: data only in the cycle after the strobe
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= READ_IDLE;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        ADDR_PIN_MUX:     reg_rdata_o <= mux_q;
        ADDR_STRAP_LOW:   reg_rdata_o <= strap_q[DATA_W-1:0]; // RULE_08
        ADDR_STRAP_HIGH:  reg_rdata_o <= {12'h000, strap_q[19:16]};
        ADDR_IND_POL_OVR: reg_rdata_o <= ind_q;
        default:          reg_rdata_o <= READ_IDLE;
      endcase
    end else begin
      reg_rdata_o <= READ_IDLE;
    end
  end

  // ==========================================================================
  // Strap capture
  // ==========================================================================
  lgm_strap_capture u_strap (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .strap_i (strap_i),
    .strap_o (strap_q)
  );

  // ==========================================================================
  // Clock paths
  // ==========================================================================
  // Aux pin has no divider or inverter of its own
  lgm_clk_path u_aux_clk (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .src_i   (clk_src_i),
    .code_i  ({1'b0, mux_q.aux_src}), // RULE_01
    .div2_i  (1'b0),
    .inv_i   (1'b0),
    .clk_o   (aux_clk)
  );

  lgm_clk_path u_pin_clk (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .src_i   (clk_src_i),
    .code_i  (mux_q.clk_src), // RULE_05
    .div2_i  (mux_q.clk_div2), // RULE_04
    .inv_i   (mux_q.clk_inv), // RULE_06
    .clk_o   (pin_clk)
  );

  // ==========================================================================
  // Indicator levels
  // ==========================================================================
  assign ind0_lvl = lgm_ind_level(ind_evt_i[0], ind_q.ind0_pol,
                                  ind_q.ind0_en, ind_q.ind0_val); // RULE_13 RULE_14
  assign ind1_lvl = lgm_ind_level(ind_evt_i[1], ind_q.ind1_pol,
                                  ind_q.ind1_en, ind_q.ind1_val); // RULE_11 RULE_12
  assign ind2_lvl = lgm_ind_level(ind_evt_i[2], ind_q.ind2_pol,
                                  ind_q.ind2_en, ind_q.ind2_val); // RULE_09 RULE_10

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Clock levels come two cycles late from the paths; the pin stages keep
  // every output on a flop at the cost of one more cycle of lag.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aux_pin_o <= 1'b0;
    end else begin
      aux_pin_o <= lgm_pin_level(mux_q.aux_sel, ind1_lvl, aux_clk, irq_i); // RULE_02 RULE_15
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clk_pin_o <= 1'b0;
    end else begin
      clk_pin_o <= lgm_pin_level(mux_q.clk_sel, ind1_lvl, pin_clk, irq_i); // RULE_07 RULE_15
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ind0_pin_o <= 1'b0;
    end else begin
      ind0_pin_o <= ind0_lvl;
    end
  end

  // Remapped indicator 2 releases the pin and feeds transmit error
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ind2_pin_o    <= 1'b0;
      ind2_pin_oe_o <= 1'b0;
      tx_er_o       <= 1'b0;
    end else begin
      ind2_pin_o    <= mux_q.transmit_error_remap ? 1'b0 : ind2_lvl; // RULE_03
      ind2_pin_oe_o <= ~mux_q.transmit_error_remap; // RULE_03
      tx_er_o       <= mux_q.transmit_error_remap & ind2_pin_i; // RULE_03
    end
  end

endmodule : lgm_pin_mux

// ### verif/lgm_board_model.sv
// Board side: clock source levels and the far end of indicator pin 2.
// Assumes the bench sets the far-end drive used while the block listens.
`timescale 1ns/10ps
module lgm_board_model
  import lgm_pkg::*;
(
  // Clock
  input  wire logic                   clk_i,
  // Indicator 2 pin
  input  wire logic                   ind2_pin_o,
  input  wire logic                   ind2_pin_oe_o,
  input  wire logic                   ext_drv_i,
  output logic                        ind2_pin_i,
  // Clock sources
  output logic [NUM_CLK_SRC-1:0]      src_o
);
  // No pull on the pin, so the far end drives whenever the block does not
  assign ind2_pin_i = ind2_pin_oe_o ? ind2_pin_o : ext_drv_i;
  // Random levels, redrawn on every edge, vary each source independently of its neighbours
  initial src_o = '0;
  always @(posedge clk_i) src_o <= NUM_CLK_SRC'($urandom);
endmodule : lgm_board_model

// ### verif/lgm_pin_mux_checker.sv
// Checker bound to the pin mux top; shadows the two config registers.
// Assumes config changes only through register writes.
`timescale 1ns/10ps
module lgm_pin_mux_checker
  import lgm_pkg::*;
(
  // Clock, reset, writes
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_we_i,
  // Sources
  input wire logic [2:0]        ind_evt_i,
  input wire logic              ind2_pin_i,
  // Pins
  input wire logic              ind2_pin_o,
  input wire logic              ind2_pin_oe_o,
  input wire logic              ind0_pin_o,
  input wire logic              aux_pin_o,
  input wire logic              clk_pin_o,
  input wire logic              tx_er_o
);
  lgm_pin_mux_t mx_q;
  lgm_ind_cfg_t ic_q;
  logic [1:0]   up_q;
  logic         ok;

  assign ok = up_q == 2'h3;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mx_q <= RST_PIN_MUX;
      ic_q <= RST_IND_POL_OVR;
    end else if (reg_we_i && reg_addr_i == ADDR_PIN_MUX) begin
      mx_q <= reg_wdata_i;
    end else if (reg_we_i && reg_addr_i == ADDR_IND_POL_OVR) begin
      ic_q <= reg_wdata_i & MASK_IND_POL_OVR;
    end
  end
  // Pin flops need a few edges after each reset release
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      up_q <= 2'h0;
    end else if (!ok) begin
      up_q <= up_q + 2'h1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_clk_pin_const: assert property (
    ok && mx_q.clk_sel > SEL_IRQ && $stable(mx_q) |-> clk_pin_o == (mx_q.clk_sel == SEL_ONE))
    else $error("clk pin constant wrong");
  a_aux_pin_const: assert property (
    ok && mx_q.aux_sel > SEL_IRQ && $stable(mx_q) |-> aux_pin_o == (mx_q.aux_sel == SEL_ONE))
    else $error("aux pin constant wrong");
  a_reserved_src_low: assert property (
    (ok && mx_q.clk_sel == SEL_CLOCK && !CLK_SRC_VALID[mx_q.clk_src] && $stable(mx_q)) [*3]
    |-> !clk_pin_o) else $error("reserved source not low");
  a_ind0_level: assert property (ok && $stable(ic_q) |->
    ind0_pin_o == (ic_q.ind0_en ? ic_q.ind0_val : $past(ind_evt_i[0]) ~^ ic_q.ind0_pol))
    else $error("ind0 level wrong");
  a_ind2_level: assert property (ok && ind2_pin_oe_o && $stable(ic_q) |->
    ind2_pin_o == (ic_q.ind2_en ? ic_q.ind2_val : $past(ind_evt_i[2]) ~^ ic_q.ind2_pol))
    else $error("ind2 level wrong");
  a_aux_ind1: assert property (
    ok && mx_q.aux_sel == SEL_IND1 && $stable(mx_q) && $stable(ic_q) |->
    aux_pin_o == (ic_q.ind1_en ? ic_q.ind1_val : $past(ind_evt_i[1]) ~^ ic_q.ind1_pol))
    else $error("ind1 level wrong");
  a_remap_on: assert property (ok && mx_q.transmit_error_remap && $stable(mx_q) |->
    !ind2_pin_oe_o && tx_er_o == $past(ind2_pin_i)) else $error("remap input wrong");
  a_remap_off: assert property (ok && !mx_q.transmit_error_remap && $stable(mx_q) |->
    ind2_pin_oe_o && !tx_er_o) else $error("pin 2 not driving");

  c_div_clock: cover property (mx_q.clk_sel == SEL_CLOCK && mx_q.clk_div2 && clk_pin_o);
  c_tx_error: cover property (tx_er_o);
  c_override: cover property (ic_q.ind2_en && ind2_pin_oe_o);
endmodule : lgm_pin_mux_checker

bind lgm_pin_mux lgm_pin_mux_checker u_chk (
  .clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .ind_evt_i, .ind2_pin_i,
  .ind2_pin_o, .ind2_pin_oe_o, .ind0_pin_o, .aux_pin_o, .clk_pin_o, .tx_er_o
);

// ### verif/lgm_pin_mux_test.sv
// Bench for the pin mux block: registers, indicators, selects, clocks.
// Assumes the board model supplies clock sources and the far end of pin 2.
`timescale 1ns/10ps
module lgm_pin_mux_test
  import lgm_pkg::*;
;
  logic                   clk_i, rst_b_i, reg_we_i, reg_re_i, irq_i, ext_drv;
  logic                   ind2_pin_i, ind2_pin_o, ind2_pin_oe_o, ind0_pin_o;
  logic                   aux_pin_o, clk_pin_o, tx_er_o, i1;
  logic [ADDR_W-1:0]      reg_addr_i;
  logic [DATA_W-1:0]      reg_wdata_i, reg_rdata_o;
  logic [NUM_CLK_SRC-1:0] clk_src_i;
  logic [3:0][15:0]       h;
  logic [2:0]             ind_evt_i, s;
  lgm_strap_t             strap_i, sv;
  lgm_ind_cfg_t           c;
  int                     num_errors, check_count, cyc;

  lgm_pin_mux uut (
    .clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
    .clk_src_i, .ind_evt_i, .irq_i, .strap_i, .ind2_pin_i, .ind2_pin_o, .ind2_pin_oe_o,
    .ind0_pin_o, .aux_pin_o, .clk_pin_o, .tx_er_o
  );
  lgm_board_model board (
    .clk_i, .ind2_pin_o, .ind2_pin_oe_o, .ext_drv_i(ext_drv), .ind2_pin_i, .src_o(clk_src_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Source history, h[0] sampled at the latest edge
  always @(posedge clk_i) h <= {h[2:0], clk_src_i};
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask : rdc

  function automatic logic ind_exp(logic e, logic p, logic en, logic v);
    return en ? v : (p ? e : !e);
  endfunction : ind_exp

  // Clock code is run with a reserved source, so it reads as low
  function automatic logic sel_exp(logic [2:0] sl, logic ind1, logic q);
    case (sl)
      3'h0: return ind1;
      3'h2: return q;
      3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : sel_exp

  // Divided output: toggle count, and every toggle on a rising source sample
  task automatic clk_run(input logic a, input logic [3:0] k, input logic d, input logic n);
    int   tg;
    int   rs;
    logic p;
    logic v;
    tg = 0;
    rs = 0;
    wr(ADDR_PIN_MUX, {k[2:0], a ? SEL_CLOCK : SEL_ZERO, 1'b0, d, k, n, a ? SEL_ZERO : SEL_CLOCK});
    repeat (5) @(posedge clk_i);
    #1;
    p = a ? aux_pin_o : clk_pin_o;
    repeat (40) begin
      @(posedge clk_i);
      #1;
      v = a ? aux_pin_o : clk_pin_o;
      if (!CLK_SRC_VALID[k]) chk(v, 1'b0);
      else if (d) begin
        tg += int'(v != p);
        rs += int'(h[2][k] && !h[3][k]);
        if (v != p) chk(h[2][k] && !h[3][k], 1'b1);
      end else chk(v, h[2][k] ^ (n && !a));
      p = v;
    end
    if (d) chk(tg - rs inside {[-1:1]}, 1'b1);
  endtask : clk_run

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    void'($urandom(65));
    {reg_we_i, reg_re_i, irq_i, ext_drv, rst_b_i} = '0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    ind_evt_i = '0;
    strap_i = lgm_strap_t'(20'($urandom));
    sv = strap_i;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    strap_i <= ~sv;
    rdc(ADDR_PIN_MUX, RST_PIN_MUX);
    rdc(ADDR_IND_POL_OVR, RST_IND_POL_OVR);
    wr(ADDR_STRAP_LOW, 16'hffff);
    rdc(ADDR_STRAP_LOW, sv[15:0]);
    rdc(ADDR_STRAP_HIGH, {12'h000, sv[19:16]});
    rdc(12'h0100, READ_IDLE);
    wr(ADDR_IND_POL_OVR, 16'hffff);
    rdc(ADDR_IND_POL_OVR, MASK_IND_POL_OVR);
    wr(ADDR_PIN_MUX, 16'ha5c3);
    rdc(ADDR_PIN_MUX, 16'ha5c3);
    $display("test registers done");
    wr(ADDR_PIN_MUX, RST_PIN_MUX);
    for (int i = 0; i < 24; i++) begin
      c = DATA_W'($urandom) & MASK_IND_POL_OVR;
      wr(ADDR_IND_POL_OVR, c);
      @(posedge clk_i);
      ind_evt_i <= 3'($urandom);
      @(posedge clk_i);
      #1;
      i1 = ind_exp(ind_evt_i[1], c.ind1_pol, c.ind1_en, c.ind1_val);
      chk(ind0_pin_o, ind_exp(ind_evt_i[0], c.ind0_pol, c.ind0_en, c.ind0_val));
      chk(ind2_pin_o, ind_exp(ind_evt_i[2], c.ind2_pol, c.ind2_en, c.ind2_val));
      chk({aux_pin_o, clk_pin_o}, {i1, i1});
    end
    $display("test indicators done");
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      wr(ADDR_PIN_MUX, {3'h7, s, 2'h0, 4'h7, 1'b1, 3'h7 - s});
      repeat (3) @(posedge clk_i);
      repeat (4) begin
        @(posedge clk_i);
        irq_i <= 1'($urandom);
        ind_evt_i <= 3'($urandom);
        @(posedge clk_i);
        #1;
        i1 = ind_exp(ind_evt_i[1], c.ind1_pol, c.ind1_en, c.ind1_val);
        chk(aux_pin_o, sel_exp(s, i1, irq_i));
        chk(clk_pin_o, sel_exp(3'h7 - s, i1, irq_i));
      end
    end
    $display("test selects done");
    for (int k = 0; k < 16; k++) clk_run(1'b0, 4'(k), 1'b0, 1'($urandom));
    for (int k = 0; k < 8; k++) clk_run(1'b1, 4'(k), 1'b0, 1'b0);
    clk_run(1'b0, 4'h8, 1'b1, 1'b0);
    clk_run(1'b0, 4'h3, 1'b1, 1'b1);
    $display("test clocks done");
    wr(ADDR_PIN_MUX, 16'h0200);
    repeat (8) begin
      @(posedge clk_i);
      ext_drv <= 1'($urandom);
      @(posedge clk_i);
      #1;
      chk({ind2_pin_oe_o, tx_er_o}, {1'b0, ext_drv});
    end
    wr(ADDR_PIN_MUX, RST_PIN_MUX);
    repeat (2) @(posedge clk_i);
    #1;
    chk({ind2_pin_oe_o, tx_er_o}, 2'h2);
    $display("test remap done");
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    sv = strap_i;
    rdc(ADDR_PIN_MUX, RST_PIN_MUX);
    rdc(ADDR_STRAP_LOW, sv[15:0]);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : lgm_pin_mux_test
